// [logic/line_irq_pkg.sv]
package line_irq_pkg;

    // ------------------------------------------------------------
    // Register address layout
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 9;
    localparam int          PAGE_LSB      = 4;
    localparam logic [4:0]  GLOBAL_PAGE   = 5'h1F;

    // Per-channel register indices
    localparam logic [3:0]  IDX_LIVE_0    = 4'h0;
    localparam logic [3:0]  IDX_LIVE_1    = 4'h1;
    localparam logic [3:0]  IDX_EDGE_SEL  = 4'h2;
    localparam logic [3:0]  IDX_PEND_0    = 4'h3;
    localparam logic [3:0]  IDX_PEND_1    = 4'h4;
    localparam logic [3:0]  IDX_PEND_2    = 4'h5;
    localparam logic [3:0]  IDX_MASK_0    = 4'h6;
    localparam logic [3:0]  IDX_MASK_1    = 4'h7;
    localparam logic [3:0]  IDX_MASK_2    = 4'h8;

    // Global page register indices
    localparam logic [3:0]  IDX_GLB_CFG   = 4'h0;
    localparam logic [3:0]  IDX_TMR_PEND  = 4'h1;
    localparam logic [3:0]  IDX_SUMMARY_1 = 4'h2;
    localparam logic [3:0]  IDX_SUMMARY_4 = 4'h5;

    // ------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  PEND0_BITS    = 8'h00_FF;
    localparam logic [7:0]  PEND1_BITS    = 8'h00_E3;
    localparam logic [7:0]  PEND2_BITS    = 8'h00_3F;
    localparam logic [7:0]  EDGE_BITS     = 8'h00_7F;
    localparam logic [7:0]  GCF_BITS      = 8'h00_03;
    localparam logic [7:0]  TMR_BITS      = 8'h00_01;
    localparam logic [7:0]  EDGE_RESET    = 8'h00_00;
    localparam logic [7:0]  GCF_RESET     = 8'h00_03;

    // Field positions
    localparam int          GCF_TMR_MASK  = 0;
    localparam int          GCF_GLB_MASK  = 1;
    localparam int          TMR_PEND_BIT  = 0;

endpackage

// [logic/line_unit_interrupt_ctrl.sv]
`timescale 1ns/1ps

// How it works
// - Twenty sources: nineteen per channel, one global timer source.
// - Sources one to ten keep a live status bit beside the pending bit.
// - Edge-select picks rising-only or any change of live bit to set pending.
// - Sources eleven to twenty set their pending bit directly per event.
// - Global mask bit 1 of global config blocks every source from outputs.
// - Each source has its own mask bit blocking it from outputs.
// - Any unmasked pending event drives the active-low interrupt pin.
// - Unmasked pending per-channel source sets that channel's summary flag.
// - Host writes one to a pending bit to clear it.
// - Summary flag stays until all that channel's pending bits are cleared.
// - Pin goes inactive only once every pending interrupt is cleared.
// - Live status bits sit at the fixed positions of both status registers.
// - Edge-select bits: shared LOS, AIS, inband; separate for the others.
// - Pending/mask 0 hold jitter FIFO and amplitude at b5, b6, b7.
// - Pending/mask 2 hold violation, zeros, error, counter sources b5..b0.
// - Timer expiry sets timer pending b0, masked by global config b0.
// - Hardware and global software resets leave every source masked.
// - Channel software reset masks only that channel's sources.
module line_unit_interrupt_ctrl
    import line_irq_pkg::*;
#(
    parameter int NUM_CHANNELS = 22
)(
    input  wire logic                          core_clk,
    input  wire logic                          reset_n,
    input  wire logic                          global_soft_reset,
    input  wire logic [NUM_CHANNELS-1:0]       chan_soft_reset,
    // Register port
    input  wire logic [ADDR_W-1:0]             reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [7:0]                    reg_wdata,
    output logic      [7:0]                    reg_rdata,
    // Live conditions {tx_overcurrent, tx_clock_loss, tx_los, system_los, line_los}
    input  wire logic [NUM_CHANNELS-1:0][4:0]  live_cond_0,
    // Live conditions {system_ais, line_ais, pattern_sync, activate, deactivate}
    input  wire logic [NUM_CHANNELS-1:0][4:0]  live_cond_1,
    // Event pulses {amplitude_overflow, tx_jitter_fifo, rx_jitter_fifo}
    input  wire logic [NUM_CHANNELS-1:0][2:0]  event_0,
    // Event pulses {sys_bpv, line_bpv, sys_exz, line_exz, pattern_err, cnt_ovf}
    input  wire logic [NUM_CHANNELS-1:0][5:0]  event_2,
    input  wire logic                          second_timer_tick,
    // Outputs
    output logic      [NUM_CHANNELS-1:0]       channel_summary_flag,
    output logic                               irq_n_out,
    output logic                               irq_n_oe_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Rising edges always count; falling edges count where sel is set
    function automatic logic [7:0] edge_set(input logic [7:0] now, input logic [7:0] old,
                                            input logic [7:0] sel);
        edge_set = (now & ~old) | (sel & old & ~now);
    endfunction

    // Write-one-to-clear with the set winning over the clear
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic hit,
                                       input logic [7:0] data, input logic [7:0] set,
                                       input logic [7:0] bits);
        w1c = ((cur & ~(hit ? data : 8'h00_00)) | set) & bits;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [NUM_CHANNELS-1:0][7:0] live_status_0;
    logic [NUM_CHANNELS-1:0][7:0] live_status_1;
    logic [NUM_CHANNELS-1:0][7:0] edge_select;
    logic [NUM_CHANNELS-1:0][7:0] pending_0;
    logic [NUM_CHANNELS-1:0][7:0] pending_1;
    logic [NUM_CHANNELS-1:0][7:0] pending_2;
    logic [NUM_CHANNELS-1:0][7:0] mask_0;
    logic [NUM_CHANNELS-1:0][7:0] mask_1;
    logic [NUM_CHANNELS-1:0][7:0] mask_2;
    logic [7:0]                   global_config;
    logic [7:0]                   timer_pending;
    logic [NUM_CHANNELS-1:0][7:0] live_now_0;
    logic [NUM_CHANNELS-1:0][7:0] live_now_1;
    logic [NUM_CHANNELS-1:0]      next_summary;
    logic                         next_irq;
    logic                         clear_all;
    logic [4:0]                   page;
    logic [3:0]                   idx;
    logic [31:0]                  summary_wide;

    // Global software reset acts exactly like the pin reset
    assign clear_all = !reset_n || global_soft_reset;
    assign page      = reg_addr[ADDR_W-1:PAGE_LSB];
    assign idx       = reg_addr[PAGE_LSB-1:0];

    // Place live conditions at their status register positions
    always_comb
    begin
        for (int c = 0; c < NUM_CHANNELS; c++)
        begin
            live_now_0[c] = {3'h0, live_cond_0[c]};
            live_now_1[c] = {live_cond_1[c][4:2], 3'h0, live_cond_1[c][1:0]};
        end
    end

    // ------------------------------------------------------------
    // Live status
    // ------------------------------------------------------------
    // Previous sample doubles as the readable live status
    always_ff @(posedge core_clk)
    begin
        if (clear_all)
        begin
            live_status_0 <= '0;
            live_status_1 <= '0;
        end
        else
        begin
            live_status_0 <= live_now_0;
            live_status_1 <= live_now_1;
        end
    end

    // ------------------------------------------------------------
    // Host-written configuration
    // ------------------------------------------------------------
    // Edge select, per-channel
    always_ff @(posedge core_clk)
    begin
        for (int c = 0; c < NUM_CHANNELS; c++)
        begin
            if (clear_all)
                edge_select[c] <= EDGE_RESET;
            else if (reg_wr && page == 5'(c) && idx == IDX_EDGE_SEL)
                edge_select[c] <= reg_wdata & EDGE_BITS;
        end
    end

    // Masks come up all set; a channel reset re-masks only its own sources
    always_ff @(posedge core_clk)
    begin
        for (int c = 0; c < NUM_CHANNELS; c++)
        begin
            if (clear_all || chan_soft_reset[c])
            begin
                mask_0[c] <= PEND0_BITS;
                mask_1[c] <= PEND1_BITS;
                mask_2[c] <= PEND2_BITS;
            end
            else if (reg_wr && page == 5'(c))
            begin
                if (idx == IDX_MASK_0)
                    mask_0[c] <= reg_wdata & PEND0_BITS;
                if (idx == IDX_MASK_1)
                    mask_1[c] <= reg_wdata & PEND1_BITS;
                if (idx == IDX_MASK_2)
                    mask_2[c] <= reg_wdata & PEND2_BITS;
            end
        end
    end

    // Global config holds both global and timer masks
    always_ff @(posedge core_clk)
    begin
        if (clear_all)
            global_config <= GCF_RESET;
        else if (reg_wr && page == GLOBAL_PAGE && idx == IDX_GLB_CFG)
            global_config <= reg_wdata & GCF_BITS;
    end

    // ------------------------------------------------------------
    // Sticky pending bits
    // ------------------------------------------------------------
    // Edge sources map through shared and separate select bits
    always_ff @(posedge core_clk)
    begin
        for (int c = 0; c < NUM_CHANNELS; c++)
        begin
            if (clear_all)
            begin
                pending_0[c] <= '0;
                pending_1[c] <= '0;
                pending_2[c] <= '0;
            end
            else
            begin
                pending_0[c] <= w1c(pending_0[c], reg_wr && page == 5'(c) && idx == IDX_PEND_0,
                                    reg_wdata,
                                    edge_set(live_now_0[c], live_status_0[c],
                                             {3'h0, edge_select[c][4:1], edge_select[c][1]})
                                    | {event_0[c], 5'h00}, PEND0_BITS);
                pending_1[c] <= w1c(pending_1[c], reg_wr && page == 5'(c) && idx == IDX_PEND_1,
                                    reg_wdata,
                                    edge_set(live_now_1[c], live_status_1[c],
                                             {edge_select[c][6], edge_select[c][6:5], 3'h0,
                                              edge_select[c][0], edge_select[c][0]}),
                                    PEND1_BITS);
                pending_2[c] <= w1c(pending_2[c], reg_wr && page == 5'(c) && idx == IDX_PEND_2,
                                    reg_wdata, {2'h0, event_2[c]}, PEND2_BITS);
            end
        end
    end

    // Global one-second timer source
    always_ff @(posedge core_clk)
    begin
        if (clear_all)
            timer_pending <= '0;
        else
            timer_pending <= w1c(timer_pending,
                                 reg_wr && page == GLOBAL_PAGE && idx == IDX_TMR_PEND,
                                 reg_wdata, {7'h00, second_timer_tick}, TMR_BITS);
    end

    // ------------------------------------------------------------
    // Summary flags and interrupt pin
    // ------------------------------------------------------------
    // Flags follow pending state directly, so they drop only after all acks
    always_comb
    begin
        for (int c = 0; c < NUM_CHANNELS; c++)
            next_summary[c] = !global_config[GCF_GLB_MASK] &&
                              |((pending_0[c] & ~mask_0[c]) | (pending_1[c] & ~mask_1[c])
                                | (pending_2[c] & ~mask_2[c]));
        next_irq = |next_summary || (timer_pending[TMR_PEND_BIT] &&
                   !global_config[GCF_TMR_MASK] && !global_config[GCF_GLB_MASK]);
    end

    // Open-drain pin: only the enable moves, the driven level is always low
    always_ff @(posedge core_clk)
    begin
        if (clear_all)
        begin
            channel_summary_flag <= '0;
            irq_n_out            <= 1'b0;
            irq_n_oe_n           <= 1'b1;
        end
        else
        begin
            channel_summary_flag <= next_summary;
            irq_n_out            <= 1'b0;
            irq_n_oe_n           <= !next_irq;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data lags the address by one cycle; reads have no side effects
    assign summary_wide = 32'(channel_summary_flag);

    always_ff @(posedge core_clk)
    begin
        if (clear_all)
            reg_rdata <= '0;
        else if (page == GLOBAL_PAGE)
        begin
            case (idx)
                IDX_GLB_CFG:  reg_rdata <= global_config;
                IDX_TMR_PEND: reg_rdata <= timer_pending;
                default:      reg_rdata <= (idx >= IDX_SUMMARY_1 && idx <= IDX_SUMMARY_4) ?
                                           summary_wide[8*(idx-IDX_SUMMARY_1) +: 8] : 8'h00_00;
            endcase
        end
        else if (page < 5'(NUM_CHANNELS))
        begin
            case (idx)
                IDX_LIVE_0:   reg_rdata <= live_status_0[page];
                IDX_LIVE_1:   reg_rdata <= live_status_1[page];
                IDX_EDGE_SEL: reg_rdata <= edge_select[page];
                IDX_PEND_0:   reg_rdata <= pending_0[page];
                IDX_PEND_1:   reg_rdata <= pending_1[page];
                IDX_PEND_2:   reg_rdata <= pending_2[page];
                IDX_MASK_0:   reg_rdata <= mask_0[page];
                IDX_MASK_1:   reg_rdata <= mask_1[page];
                IDX_MASK_2:   reg_rdata <= mask_2[page];
                default:      reg_rdata <= 8'h00_00;
            endcase
        end
        else
            reg_rdata <= 8'h00_00;
    end

    // ------------------------------------------------------------
    // Checks on channel 0, the timer source and the global mask
    // ------------------------------------------------------------
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (clear_all);

    logic wr_pend2_ch0;
    assign wr_pend2_ch0 = reg_wr && page == 5'h00 && idx == IDX_PEND_2;

    chk_live_follow: assert property (##1 live_status_0[0] == $past(live_now_0[0]))
        else $error("live status did not follow its condition");
    chk_rise_sets: assert property (live_cond_0[0][4] && !live_status_0[0][4]
        |=> pending_0[0][4]) else $error("rising edge did not set pending");
    chk_fall_any: assert property (edge_select[0][4] && live_status_0[0][4]
        && !live_cond_0[0][4] |=> pending_0[0][4]) else $error("falling edge missed");
    chk_fall_ignored: assert property (!edge_select[0][4] && live_status_0[0][4]
        && !live_cond_0[0][4] && !pending_0[0][4] |=> !pending_0[0][4])
        else $error("falling edge set pending in rising mode");
    chk_event_sets: assert property (event_2[0][0] |=> pending_2[0][0])
        else $error("event did not set pending");
    chk_w1c_clear: assert property (wr_pend2_ch0 && reg_wdata[0] && !event_2[0][0]
        |=> !pending_2[0][0]) else $error("write one did not clear");
    chk_set_wins: assert property (wr_pend2_ch0 && reg_wdata[0] && event_2[0][0]
        |=> pending_2[0][0]) else $error("clear beat a new event");
    chk_zero_keeps: assert property (wr_pend2_ch0 && !reg_wdata[0] && pending_2[0][0]
        |=> pending_2[0][0]) else $error("write zero cleared pending");
    chk_global_mask: assert property (global_config[GCF_GLB_MASK] |=> irq_n_oe_n)
        else $error("pin asserted under global mask");
    chk_timer_irq: assert property (timer_pending[0] && global_config[1:0] == 2'b00
        |=> !irq_n_oe_n [*1] ##0 !irq_n_out) else $error("timer did not raise pin");
    chk_chan_flag: assert property ((|(pending_0[0] & ~mask_0[0])) && !global_config[1]
        |=> channel_summary_flag[0] && !irq_n_oe_n) else $error("summary flag missing");
    chk_chan_reset: assert property (chan_soft_reset[0] |=> mask_2[0] == PEND2_BITS)
        else $error("channel reset did not mask");
    chk_reset_masks: assert property ($past(clear_all) |-> mask_0[0] == PEND0_BITS
        && global_config == GCF_RESET) else $error("reset left a source unmasked");

    cov_edge_irq: cover property (live_cond_0[0][0] ##1 !irq_n_oe_n);
    cov_ack_release: cover property (!irq_n_oe_n ##1 wr_pend2_ch0 ##2 irq_n_oe_n);
    cov_timer: cover property (second_timer_tick ##[1:3] timer_pending[0]);

endmodule

// [verification/host_model.sv]
`timescale 1ns/1ps

module host_model
    import line_irq_pkg::*;
(
    input  wire logic              core_clk,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic                   reg_wr,
    output logic      [7:0]        reg_wdata,
    input  wire logic [7:0]        reg_rdata
);
    // --------------------------------------------------------
    // Register cycles, driven on the falling edge
    // --------------------------------------------------------
    // Idle bus at time zero
    initial
    begin
        reg_addr  = '0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end

    // One-cycle write strobe; data inverted after so stale data never passes
    task automatic wr(input logic [4:0] page, input logic [3:0] idx, input logic [7:0] data);
        @(negedge core_clk);
        reg_addr  = {page, idx};
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~data;
    endtask

    // Read data is registered, so it is taken one cycle after the address
    task automatic rd(input logic [4:0] page, input logic [3:0] idx, output logic [7:0] data);
        @(negedge core_clk);
        reg_addr = {page, idx};
        @(negedge core_clk);
        data = reg_rdata;
    endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_top;
    import line_irq_pkg::*;
    localparam int NCH = 4;

    logic                core_clk = 1'b0;
    logic                reset_n = 1'b0;
    logic                global_soft_reset = 1'b0;
    logic [NCH-1:0]      chan_soft_reset = '0;
    logic [ADDR_W-1:0]   reg_addr;
    logic                reg_wr;
    logic [7:0]          reg_wdata;
    logic [7:0]          reg_rdata;
    logic [NCH-1:0][4:0] live_cond_0 = '0;
    logic [NCH-1:0][4:0] live_cond_1 = '0;
    logic [NCH-1:0][2:0] event_0 = '0;
    logic [NCH-1:0][5:0] event_2 = '0;
    logic                second_timer_tick = 1'b0;
    logic [NCH-1:0]      channel_summary_flag;
    logic                irq_n_out;
    logic                irq_n_oe_n;
    int                  error_cnt = 0;
    int                  num_checks = 0;

    // --------------------------------------------------------
    // Clock, design and host
    // --------------------------------------------------------
    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    line_unit_interrupt_ctrl #(.NUM_CHANNELS(NCH)) line_unit_interrupt_ctrl_inst (
        .core_clk(core_clk), .reset_n(reset_n), .global_soft_reset(global_soft_reset),
        .chan_soft_reset(chan_soft_reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .live_cond_0(live_cond_0),
        .live_cond_1(live_cond_1), .event_0(event_0), .event_2(event_2),
        .second_timer_tick(second_timer_tick), .channel_summary_flag(channel_summary_flag),
        .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n));

    host_model host_model_inst (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // --------------------------------------------------------
    // Expectation tables and stimulus helpers
    // --------------------------------------------------------
    // Live source k: 0..4 first status register, 5..9 second
    function automatic logic [7:0] lbit(input int k);
        int pos [10] = '{0, 1, 2, 3, 4, 0, 1, 5, 6, 7};
        return 8'h01 << pos[k];
    endfunction

    // Shared edge-select bits for LOS, AIS and inband pairs
    function automatic logic [7:0] ebit(input int k);
        int pos [10] = '{1, 1, 2, 3, 4, 0, 0, 5, 6, 6};
        return 8'h01 << pos[k];
    endfunction

    // Event source k: 0..2 upper bits of pending_0, 3..8 low bits of pending_2
    function automatic logic [7:0] vbit(input int k);
        return (k < 3) ? (8'h20 << k) : (8'h01 << (k - 3));
    endfunction

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic live(input int ch, input int k, input logic v);
        @(negedge core_clk);
        if (k < 5) live_cond_0[ch][k] = v;
        else live_cond_1[ch][k-5] = v;
    endtask

    // One-cycle event pulse
    task automatic ev(input int ch, input int k);
        @(negedge core_clk);
        if (k < 3) event_0[ch][k] = 1'b1;
        else event_2[ch][k-3] = 1'b1;
        @(negedge core_clk);
        event_0[ch] = '0;
        event_2[ch] = '0;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        logic [7:0] d;
        logic [3:0] idx;
        int         ch;
        int         seed_val;
        seed_val = $urandom(69);
        step(4);
        reset_n = 1'b1;
        // Reset leaves every source masked
        host_model_inst.rd(0, IDX_MASK_0, d);   `CHK("mask_0", 8'hFF, d)
        host_model_inst.rd(0, IDX_MASK_1, d);   `CHK("mask_1", 8'hE3, d)
        host_model_inst.rd(0, IDX_MASK_2, d);   `CHK("mask_2", 8'h3F, d)
        host_model_inst.rd(5'h1F, IDX_GLB_CFG, d); `CHK("gcf", 8'h03, d)
        `CHK("irq_oe", 1'b1, irq_n_oe_n)
        host_model_inst.wr(0, IDX_LIVE_0, 8'hFF);
        host_model_inst.rd(0, IDX_LIVE_0, d);   `CHK("live_ro", 8'h00, d)
        // Unmask channel 0 and the global masks only
        host_model_inst.wr(5'h1F, IDX_GLB_CFG, 8'h00);
        host_model_inst.wr(0, IDX_MASK_0, 8'h00);
        host_model_inst.wr(0, IDX_MASK_1, 8'h00);
        host_model_inst.wr(0, IDX_MASK_2, 8'h00);
        // Every live source: rising, both-edge and rising-only falls
        for (int k = 0; k < 10; k++)
        begin
            idx = (k < 5) ? IDX_PEND_0 : IDX_PEND_1;
            live(0, k, 1'b1);
            step(2);
            `CHK("flag", 1'b1, channel_summary_flag[0])
            `CHK("irq_on", 1'b0, irq_n_oe_n)
            host_model_inst.rd(0, (k < 5) ? IDX_LIVE_0 : IDX_LIVE_1, d);
            `CHK("live", lbit(k), d)
            host_model_inst.rd(0, idx, d);  `CHK("pend_rise", lbit(k), d)
            host_model_inst.wr(0, idx, lbit(k));
            step(1);
            `CHK("flag_clr", 1'b0, channel_summary_flag[0])
            `CHK("irq_off", 1'b1, irq_n_oe_n)
            host_model_inst.wr(0, IDX_EDGE_SEL, ebit(k));
            live(0, k, 1'b0);
            step(2);
            host_model_inst.rd(0, idx, d);  `CHK("pend_fall", lbit(k), d)
            host_model_inst.wr(0, idx, lbit(k));
            host_model_inst.wr(0, IDX_EDGE_SEL, 8'h00);
            live(0, k, 1'b1);
            step(2);
            host_model_inst.wr(0, idx, lbit(k));
            live(0, k, 1'b0);
            step(2);
            host_model_inst.rd(0, idx, d);  `CHK("pend_rise_only", 8'h00, d)
        end
        // Event sources on random channels; only channel 0 is unmasked
        for (int n = 0; n < 18; n++)
        begin
            // First pass pins channel 0 so every source hits the checks there
            ch = (n < 9) ? 0 : $urandom_range(NCH - 1, 0);
            idx = (n % 9 < 3) ? IDX_PEND_0 : IDX_PEND_2;
            ev(ch, n % 9);
            host_model_inst.rd(ch, idx, d); `CHK("pend_ev", vbit(n % 9), d)
            `CHK("flag_mask", (ch == 0), channel_summary_flag[ch])
            `CHK("irq_mask", (ch != 0), irq_n_oe_n)
            host_model_inst.wr(ch, idx, 8'h00);
            host_model_inst.rd(ch, idx, d); `CHK("wr_zero", vbit(n % 9), d)
            host_model_inst.wr(ch, idx, vbit(n % 9));
            host_model_inst.rd(ch, idx, d); `CHK("wr_one", 8'h00, d)
        end
        // Two channels pending, then per-channel and global release
        host_model_inst.wr(1, IDX_MASK_2, 8'h00);
        ev(0, 3);
        ev(1, 3);
        host_model_inst.rd(5'h1F, IDX_SUMMARY_1, d); `CHK("summary", 8'h03, d)
        host_model_inst.wr(0, IDX_PEND_2, 8'h01);
        step(1);
        `CHK("flags", 4'b0010, channel_summary_flag)
        `CHK("irq_hold", 1'b0, irq_n_oe_n)
        host_model_inst.wr(5'h1F, IDX_GLB_CFG, 8'h02);
        step(1);
        `CHK("glb_mask", 1'b1, irq_n_oe_n)
        host_model_inst.wr(5'h1F, IDX_GLB_CFG, 8'h00);
        // Clearing write in the same cycle as a new event
        fork
            host_model_inst.wr(0, IDX_PEND_2, 8'h01);
            ev(0, 3);
        join
        host_model_inst.rd(0, IDX_PEND_2, d); `CHK("clr_race", 8'h01, d)
        host_model_inst.wr(0, IDX_PEND_2, 8'h01);
        host_model_inst.wr(1, IDX_PEND_2, 8'h01);
        step(1);
        `CHK("irq_idle", 1'b1, irq_n_oe_n)
        // Timer source, masked and then unmasked
        host_model_inst.wr(5'h1F, IDX_GLB_CFG, 8'h01);
        @(negedge core_clk) second_timer_tick = 1'b1;
        @(negedge core_clk) second_timer_tick = 1'b0;
        step(1);
        host_model_inst.rd(5'h1F, IDX_TMR_PEND, d); `CHK("tmr_pend", 8'h01, d)
        `CHK("tmr_masked", 1'b1, irq_n_oe_n)
        host_model_inst.wr(5'h1F, IDX_GLB_CFG, 8'h00);
        step(1);
        `CHK("tmr_irq", 1'b0, irq_n_oe_n)
        `CHK("irq_level", 1'b0, irq_n_out)
        `CHK("tmr_noflag", 4'b0000, channel_summary_flag)
        host_model_inst.wr(5'h1F, IDX_TMR_PEND, 8'h01);
        // Channel reset re-masks only its own channel
        @(negedge core_clk) chan_soft_reset[0] = 1'b1;
        @(negedge core_clk) chan_soft_reset[0] = 1'b0;
        host_model_inst.rd(0, IDX_MASK_0, d); `CHK("ch_rst_own", 8'hFF, d)
        host_model_inst.rd(1, IDX_MASK_2, d); `CHK("ch_rst_other", 8'h00, d)
        // Global software reset masks everything again
        @(negedge core_clk) global_soft_reset = 1'b1;
        @(negedge core_clk) global_soft_reset = 1'b0;
        host_model_inst.rd(1, IDX_MASK_2, d); `CHK("glb_rst_mask", 8'h3F, d)
        host_model_inst.rd(5'h1F, IDX_GLB_CFG, d); `CHK("glb_rst_gcf", 8'h03, d)
        wrap_up();
    end
endmodule
